// [rtl/pmg_power_mgmt.sv]
`timescale 1ns/1ps
module pmg_power_mgmt
  import pmg_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // APB slave
  input wire pmg_apb_req_t apb_req_in,
  output pmg_apb_rsp_t apb_rsp_out,
  // Board inputs, asynchronous
  input wire logic power_button_n_in,
  input wire logic reset_button_n_in,
  input wire logic main_supply_good_in,
  input wire logic main_supply_rail_low_in,
  input wire logic expansion_wake_n_in,
  input wire logic general_wake_n_in,
  input wire logic battery_low_n_in,
  input wire logic over_temp_in_n_in,
  input wire logic mgmt_bus_alert_n_in,
  input wire logic lid_n_in,
  input wire logic sleep_button_n_in,
  input wire logic [3:0] usb_overcurrent_n_in,
  // Board outputs
  output logic carrier_reset_out_n_out,
  output logic suspend_imminent_n_out,
  output logic suspend_to_ram_n_out,
  output logic suspend_to_disk_n_out,
  output logic soft_off_n_out,
  output logic thermal_trip_out_n_out,
  output logic watchdog_timeout_out_out,
  output logic mgmt_interrupt_out,
  output logic irq_out
);

  logic [PMG_NUM_IN-1:0] raw_in;
  logic [PMG_NUM_IN-1:0] sync1_reg;
  logic [PMG_NUM_IN-1:0] sync2_reg;
  logic [PMG_NUM_IN-1:0] prev_reg;
  logic [PMG_NUM_IN-1:0] active;
  logic [PMG_NUM_IN-1:0] fall_ev;
  logic [PMG_NUM_EV-1:0] ev;
  logic [PMG_NUM_EV-1:0] status_reg;
  logic [PMG_NUM_EV-1:0] mask_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] wdt_cnt_reg;
  logic wdt_fire;
  logic [7:0] rst_cnt_reg;
  logic [7:0] warn_cnt_reg;
  logic sw_rst_pulse;
  logic sus_req_pulse;
  logic wake_req;
  logic sleep_req;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  pmg_state_t state_reg;
  pmg_target_t tgt;

  // Inputs except rail-low are flipped so that a one means asserted everywhere below.
  assign raw_in = {~usb_overcurrent_n_in, ~sleep_button_n_in, ~lid_n_in, ~mgmt_bus_alert_n_in,
                   ~over_temp_in_n_in, ~battery_low_n_in, ~general_wake_n_in, ~expansion_wake_n_in,
                   main_supply_rail_low_in, ~main_supply_good_in, ~reset_button_n_in,
                   ~power_button_n_in};

  // Previous levels start deasserted like the idle pins, so no false edge follows reset.
  // two-flop synchroniser
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign active = sync2_reg;
  assign fall_ev = active & ~prev_reg;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_oc
      assign ev[PMG_EV_OC0+g] = fall_ev[11+g];
    end
  endgenerate

  assign ev[PMG_EV_SUPPLY] = fall_ev[PMG_IN_SUPPLY];
  assign ev[PMG_EV_POWER_BUTTON_N] = fall_ev[PMG_IN_POWER_BUTTON_N];
  assign ev[PMG_EV_RSTBTN] = fall_ev[PMG_IN_RSTBTN];
  assign ev[PMG_EV_RAIL] = fall_ev[PMG_IN_RAIL];
  assign ev[PMG_EV_XWAKE] = fall_ev[4];
  assign ev[PMG_EV_GWAKE] = fall_ev[5];
  assign ev[PMG_EV_BATTERY_LOW_N] = fall_ev[6];
  assign ev[PMG_EV_OTEMP] = fall_ev[7];
  assign ev[PMG_EV_ALERT] = fall_ev[8];
  assign ev[PMG_EV_LID] = fall_ev[9];
  assign ev[PMG_EV_SLEEP] = fall_ev[10];
  assign ev[PMG_EV_WDOG] = wdt_fire;

  // APB: zero wait states, unmapped addresses answer with an error.
  assign addr_ok = (apb_req_in.paddr == PMG_STATUS_OFS) || (apb_req_in.paddr == PMG_MASK_OFS) ||
                   (apb_req_in.paddr == PMG_CTRL_OFS) || (apb_req_in.paddr == PMG_LEVEL_OFS) ||
                   (apb_req_in.paddr == PMG_STATE_OFS);
  assign wr_en = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && addr_ok;
  assign rd_en = apb_req_in.psel && !apb_req_in.pwrite && !apb_req_in.penable;
  assign sw_rst_pulse = wr_en && (apb_req_in.paddr == PMG_CTRL_OFS) && apb_req_in.pwdata[PMG_CTL_SWRST];
  assign sus_req_pulse = wr_en && (apb_req_in.paddr == PMG_CTRL_OFS) && apb_req_in.pwdata[PMG_CTL_SUSREQ];

  // A suspend request may carry its target in the same write, so the written target wins.
  always_comb
  begin
    tgt = pmg_target_t'(ctrl_reg[PMG_CTL_TGT_LO+:2]);
    if (wr_en && (apb_req_in.paddr == PMG_CTRL_OFS))
    begin
      tgt = pmg_target_t'(apb_req_in.pwdata[PMG_CTL_TGT_LO+:2]);
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      apb_rsp_out <= '0;
    end
    else
    begin
      apb_rsp_out.pready <= apb_req_in.psel && !apb_req_in.penable;
      apb_rsp_out.pslverr <= apb_req_in.psel && !apb_req_in.penable && !addr_ok;
      if (rd_en)
      begin
        unique case (apb_req_in.paddr)
          PMG_STATUS_OFS: apb_rsp_out.prdata <= {16'h0000, status_reg};
          PMG_MASK_OFS: apb_rsp_out.prdata <= {16'h0000, mask_reg};
          PMG_CTRL_OFS: apb_rsp_out.prdata <= ctrl_reg;
          PMG_LEVEL_OFS: apb_rsp_out.prdata <= {17'h0, active};
          PMG_STATE_OFS: apb_rsp_out.prdata <= {29'h0, 3'(state_reg)};
          default: apb_rsp_out.prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Pulse bits of control self-clear so they act once per write.
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      ctrl_reg <= {PMG_WDT_RST, 16'h0000};
      mask_reg <= PMG_MASK_RST;
    end
    else if (wr_en)
    begin
      if (apb_req_in.paddr == PMG_CTRL_OFS)
      begin
        ctrl_reg <= apb_req_in.pwdata & ~32'h00000023;
      end
      if (apb_req_in.paddr == PMG_MASK_OFS)
      begin
        mask_reg <= apb_req_in.pwdata[PMG_NUM_EV-1:0];
      end
    end
  end

  // Write one to clear; a new event in the same cycle wins.
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      status_reg <= '0;
    end
    else if (wr_en && (apb_req_in.paddr == PMG_STATUS_OFS))
    begin
      status_reg <= (status_reg & ~apb_req_in.pwdata[PMG_NUM_EV-1:0]) | ev;
    end
    else
    begin
      status_reg <= status_reg | ev;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      irq_out <= 1'b0;
      mgmt_interrupt_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(status_reg & mask_reg);
      // alert as system management interrupt when not a wake source
      mgmt_interrupt_out <= status_reg[PMG_EV_ALERT] && !ctrl_reg[PMG_CTL_ALERT_WAKE];
    end
  end

  // Watchdog counts down while enabled; a kick reloads it.
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      wdt_cnt_reg <= PMG_WDT_RST;
      watchdog_timeout_out_out <= 1'b0;
    end
    else
    begin
      // A kick takes its reload from the written word, so one write can arm the watchdog.
      if (wr_en && (apb_req_in.paddr == PMG_CTRL_OFS) && apb_req_in.pwdata[PMG_CTL_WDT_KICK])
      begin
        wdt_cnt_reg <= apb_req_in.pwdata[PMG_CTL_WDT_LO+:16];
      end
      else if (!ctrl_reg[PMG_CTL_WDT_EN])
      begin
        wdt_cnt_reg <= ctrl_reg[PMG_CTL_WDT_LO+:16];
      end
      else if (wdt_cnt_reg != 16'h0000)
      begin
        wdt_cnt_reg <= wdt_cnt_reg - 16'h0001;
      end
      if (wdt_fire)
      begin
        watchdog_timeout_out_out <= 1'b1;
      end
      else if (!ctrl_reg[PMG_CTL_WDT_EN])
      begin
        watchdog_timeout_out_out <= 1'b0;
      end
    end
  end

  assign wdt_fire = ctrl_reg[PMG_CTL_WDT_EN] && (wdt_cnt_reg == 16'h0001);

  // Held supply and rail causes keep reloading, so the pulse ends a full width after they clear.
  // any cause stretches the carrier reset pulse
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      rst_cnt_reg <= 8'(PMG_RST_CYC);
      carrier_reset_out_n_out <= 1'b0;
    end
    else
    begin
      if (fall_ev[PMG_IN_RSTBTN] || active[PMG_IN_SUPPLY] || active[PMG_IN_RAIL] || wdt_fire ||
          sw_rst_pulse)
      begin
        rst_cnt_reg <= 8'(PMG_RST_CYC);
      end
      else if (rst_cnt_reg != 8'h00)
      begin
        rst_cnt_reg <= rst_cnt_reg - 8'h01;
      end
      carrier_reset_out_n_out <= (rst_cnt_reg == 8'h00);
    end
  end

  assign wake_req = ev[PMG_EV_POWER_BUTTON_N] || ev[PMG_EV_XWAKE] || ev[PMG_EV_GWAKE] || ev[PMG_EV_SLEEP] ||
                    (ev[PMG_EV_ALERT] && ctrl_reg[PMG_CTL_ALERT_WAKE]);
  assign sleep_req = sus_req_pulse || ev[PMG_EV_SLEEP];

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= PMG_ST_OFF;
      warn_cnt_reg <= 8'h00;
    end
    else
    begin
      unique case (state_reg)
        PMG_ST_OFF:
        begin
          if (ev[PMG_EV_POWER_BUTTON_N])
          begin
            state_reg <= PMG_ST_ON;
          end
        end
        PMG_ST_ON:
        begin
          if (sleep_req && (tgt != PMG_TGT_ON))
          begin
            state_reg <= PMG_ST_WARN;
            warn_cnt_reg <= 8'(PMG_WARN_CYC);
          end
        end
        PMG_ST_WARN:
        begin
          if (warn_cnt_reg > 8'h01)
          begin
            warn_cnt_reg <= warn_cnt_reg - 8'h01;
          end
          else
          begin
            state_reg <= (tgt == PMG_TGT_RAM) ? PMG_ST_RAM : PMG_ST_DISK;
          end
        end
        PMG_ST_RAM, PMG_ST_DISK:
        begin
          if (wake_req)
          begin
            state_reg <= PMG_ST_ON;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      suspend_imminent_n_out <= 1'b1;
      suspend_to_ram_n_out <= 1'b0;
      suspend_to_disk_n_out <= 1'b0;
      soft_off_n_out <= 1'b0;
      thermal_trip_out_n_out <= 1'b1;
    end
    else
    begin
      suspend_imminent_n_out <= !(state_reg == PMG_ST_WARN);
      // RAM indicator, also low in deeper states
      suspend_to_ram_n_out <= !(state_reg == PMG_ST_RAM || state_reg == PMG_ST_DISK ||
                                state_reg == PMG_ST_OFF);
      suspend_to_disk_n_out <= !(state_reg == PMG_ST_DISK || state_reg == PMG_ST_OFF);
      soft_off_n_out <= !(state_reg == PMG_ST_DISK || state_reg == PMG_ST_OFF);
      // thermal trip is sticky until reset
      if (ctrl_reg[PMG_CTL_TRIP])
      begin
        thermal_trip_out_n_out <= 1'b0;
      end
    end
  end

endmodule : pmg_power_mgmt

// [rtl/pmg_pkg.sv]
package pmg_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] PMG_STATUS_OFS = 8'h00;
  localparam logic [7:0] PMG_MASK_OFS = 8'h04;
  localparam logic [7:0] PMG_CTRL_OFS = 8'h08;
  localparam logic [7:0] PMG_LEVEL_OFS = 8'h0c;
  localparam logic [7:0] PMG_STATE_OFS = 8'h10;

  // Event bit positions, shared by status and mask.
  localparam int PMG_EV_POWER_BUTTON_N = 0;
  localparam int PMG_EV_RSTBTN = 1;
  localparam int PMG_EV_SUPPLY = 2;
  localparam int PMG_EV_RAIL = 3;
  localparam int PMG_EV_XWAKE = 4;
  localparam int PMG_EV_GWAKE = 5;
  localparam int PMG_EV_BATTERY_LOW_N = 6;
  localparam int PMG_EV_OTEMP = 7;
  localparam int PMG_EV_ALERT = 8;
  localparam int PMG_EV_LID = 9;
  localparam int PMG_EV_SLEEP = 10;
  localparam int PMG_EV_OC0 = 11;
  localparam int PMG_EV_WDOG = 15;
  localparam int PMG_NUM_EV = 16;
  localparam logic [15:0] PMG_MASK_RST = 16'h0000;

  // Control register fields.
  localparam int PMG_CTL_SWRST = 0;
  localparam int PMG_CTL_SUSREQ = 1;
  localparam int PMG_CTL_TGT_LO = 2;
  localparam int PMG_CTL_WDT_EN = 4;
  localparam int PMG_CTL_WDT_KICK = 5;
  localparam int PMG_CTL_TRIP = 6;
  localparam int PMG_CTL_ALERT_WAKE = 7;
  localparam int PMG_CTL_WDT_LO = 16;

  // Number of synchronised inputs.
  localparam int PMG_NUM_IN = 15;
  localparam int PMG_IN_POWER_BUTTON_N = 0;
  localparam int PMG_IN_RSTBTN = 1;
  localparam int PMG_IN_SUPPLY = 2;
  localparam int PMG_IN_RAIL = 3;

  // Timing: carrier reset pulse width and suspend warning lead time.
  localparam int PMG_CLK_HZ = 10_000_000;
  localparam int PMG_RST_PULSE_US = 10;
  localparam int PMG_RST_CYC = (PMG_RST_PULSE_US * (PMG_CLK_HZ / 1_000_000));
  localparam int PMG_WARN_US = 2;
  localparam int PMG_WARN_CYC = (PMG_WARN_US * (PMG_CLK_HZ / 1_000_000));
  localparam logic [15:0] PMG_WDT_RST = 16'hffff;

  typedef enum logic [1:0] {
    PMG_TGT_ON,
    PMG_TGT_RAM,
    PMG_TGT_DISK
  } pmg_target_t;

  typedef enum {
    PMG_ST_OFF,
    PMG_ST_ON,
    PMG_ST_WARN,
    PMG_ST_RAM,
    PMG_ST_DISK
  } pmg_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pmg_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pmg_apb_rsp_t;

endpackage : pmg_pkg

// [verif/pmg_power_mgmt_monitor.sv]
`timescale 1ns/1ps
module pmg_power_mgmt_monitor
  import pmg_pkg::*;
(
  // Clock, reset and bus
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire pmg_apb_req_t apb_req_in,
  // Board inputs
  input wire logic power_button_n_in,
  input wire logic reset_button_n_in,
  input wire logic main_supply_good_in,
  input wire logic main_supply_rail_low_in,
  input wire logic general_wake_n_in,
  // Board outputs
  input wire logic carrier_reset_out_n_out,
  input wire logic suspend_imminent_n_out,
  input wire logic suspend_to_ram_n_out,
  input wire logic suspend_to_disk_n_out,
  input wire logic soft_off_n_out,
  input wire logic thermal_trip_out_n_out,
  input wire logic watchdog_timeout_out_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  wire sw_rst = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite & apb_req_in.pwdata[0]
    & (apb_req_in.paddr == PMG_CTRL_OFS);
  property p_pwr_on;
    $fell(power_button_n_in) && !soft_off_n_out && carrier_reset_out_n_out |-> ##[2:8] soft_off_n_out;
  endproperty
  a_pwr_on: assert property (p_pwr_on) else $error("power-on missed");
  property p_rst_btn; $fell(reset_button_n_in) |-> ##[2:6] !carrier_reset_out_n_out; endproperty
  a_rst_btn: assert property (p_rst_btn) else $error("button reset missed");
  property p_supply;
    $fell(main_supply_good_in) || $rose(main_supply_rail_low_in) |-> ##[2:6] !carrier_reset_out_n_out;
  endproperty
  a_supply: assert property (p_supply) else $error("supply reset missed");
  property p_sw_rst; sw_rst |-> ##[1:4] !carrier_reset_out_n_out; endproperty
  a_sw_rst: assert property (p_sw_rst) else $error("software reset missed");
  property p_wdt; $rose(watchdog_timeout_out_out) |-> ##[0:3] !carrier_reset_out_n_out; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset missed");
  property p_warn; $fell(suspend_to_ram_n_out) |-> $past(suspend_imminent_n_out) == 1'b0; endproperty
  a_warn: assert property (p_warn) else $error("no suspend warning");
  property p_disk; !suspend_to_disk_n_out |-> !suspend_to_ram_n_out; endproperty
  a_disk: assert property (p_disk) else $error("disk without ram low");
  property p_soft; soft_off_n_out == suspend_to_disk_n_out; endproperty
  a_soft: assert property (p_soft) else $error("soft-off differs");
  property p_wake;
    $fell(general_wake_n_in) && !suspend_to_ram_n_out && suspend_to_disk_n_out |-> ##[2:8] suspend_to_ram_n_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");
  property p_trip; $fell(thermal_trip_out_n_out) |-> !thermal_trip_out_n_out [*8]; endproperty
  a_trip: assert property (p_trip) else $error("trip released");
  c_ram: cover property ($fell(suspend_to_ram_n_out));
  c_wdt: cover property ($rose(watchdog_timeout_out_out));
  c_trip: cover property ($fell(thermal_trip_out_n_out));
endmodule : pmg_power_mgmt_monitor

bind pmg_power_mgmt pmg_power_mgmt_monitor u_mon (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .apb_req_in(apb_req_in), .power_button_n_in(power_button_n_in), .reset_button_n_in(reset_button_n_in),
  .main_supply_good_in(main_supply_good_in), .main_supply_rail_low_in(main_supply_rail_low_in),
  .general_wake_n_in(general_wake_n_in), .carrier_reset_out_n_out(carrier_reset_out_n_out),
  .suspend_imminent_n_out(suspend_imminent_n_out), .suspend_to_ram_n_out(suspend_to_ram_n_out),
  .suspend_to_disk_n_out(suspend_to_disk_n_out), .soft_off_n_out(soft_off_n_out),
  .thermal_trip_out_n_out(thermal_trip_out_n_out), .watchdog_timeout_out_out(watchdog_timeout_out_out));

// [verif/pmg_carrier_model.sv]
`timescale 1ns/1ps
module pmg_carrier_model
(
  // Wanted event levels, 1 means asserted
  input wire logic [14:0] ev_in,
  // Board pins as the carrier drives them
  output logic [14:0] pin_out
);
  // supply-good is high when good, rail-low is active high.
  assign pin_out[3:0] = {ev_in[3], ~ev_in[2:0]};
  // buttons, wakes and alerts are active low.
  assign pin_out[10:4] = ~ev_in[10:4];
  // overcurrent flags are active low; the model drives both the low and the high level.
  assign pin_out[14:11] = ~ev_in[14:11];
endmodule : pmg_carrier_model

// [verif/test_pmg_power_mgmt.sv]
`timescale 1ns/1ps
module test_pmg_power_mgmt;
  import pmg_pkg::*;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  pmg_apb_req_t req = '0;
  pmg_apb_rsp_t rsp;
  logic [14:0] ev = '0;
  logic [14:0] v;
  wire [14:0] pin;
  logic cr_n, si_n, sr_n, sd_n, so_n, tt_n, wd, mi, irq;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 32'head3d602;
  int n;

  always #50 mclk_in = ~mclk_in;

  pmg_carrier_model board (.ev_in(ev), .pin_out(pin));
  pmg_power_mgmt dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .apb_req_in(req), .apb_rsp_out(rsp),
    .power_button_n_in(pin[0]), .reset_button_n_in(pin[1]), .main_supply_good_in(pin[2]),
    .main_supply_rail_low_in(pin[3]), .expansion_wake_n_in(pin[4]), .general_wake_n_in(pin[5]),
    .battery_low_n_in(pin[6]), .over_temp_in_n_in(pin[7]), .mgmt_bus_alert_n_in(pin[8]), .lid_n_in(pin[9]),
    .sleep_button_n_in(pin[10]), .usb_overcurrent_n_in(pin[14:11]), .carrier_reset_out_n_out(cr_n),
    .suspend_imminent_n_out(si_n), .suspend_to_ram_n_out(sr_n), .suspend_to_disk_n_out(sd_n),
    .soft_off_n_out(so_n), .thermal_trip_out_n_out(tt_n), .watchdog_timeout_out_out(wd),
    .mgmt_interrupt_out(mi), .irq_out(irq));

  function automatic logic [31:0] lvl(input logic [14:0] x);
    return {17'h00000, x};
  endfunction : lvl

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task wt(input int k);
    repeat (k) @(posedge mclk_in);
  endtask : wt

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_in);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk_in);
    req.penable <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (k >= 20)
    begin
      chk("pready", 1, 0);
      stop_test();
    end
  endtask : apb

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc

  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  initial
  begin
    wt(90000);
    mismatches++;
    stop_test();
  end

  initial
  begin
    wt(20);
    nrst_in <= 1'b1;
    chk("ram_n", 0, sr_n);
    chk("trip_n", 1, tt_n);
    wt(30);
    chk("cbrst", 0, cr_n);
    wt(80);
    chk("cbrst", 1, cr_n);
    rdc("mask", PMG_MASK_OFS, PMG_MASK_RST);
    rdc("state", PMG_STATE_OFS, 0);
    ev[0] <= 1'b1;
    wt(8);
    ev[0] <= 1'b0;
    rdc("state", PMG_STATE_OFS, 1);
    apb(1, PMG_MASK_OFS, 1);
    wt(3);
    chk("irq", 1, irq);
    apb(1, PMG_STATUS_OFS, 1);
    wt(3);
    chk("irq", 0, irq);
    $display("power-on test done");
    apb(1, PMG_CTRL_OFS, 32'h6);
    wt(4);
    chk("warn_n", 0, si_n);
    chk("ram_n", 1, sr_n);
    wt(30);
    chk("ram_n", 0, sr_n);
    chk("disk_n", 1, sd_n);
    ev[5] <= 1'b1;
    wt(8);
    ev[5] <= 1'b0;
    rdc("state", PMG_STATE_OFS, 1);
    apb(1, PMG_CTRL_OFS, 32'h8);
    ev[10] <= 1'b1;
    wt(8);
    ev[10] <= 1'b0;
    wt(30);
    chk("disk_n", 0, sd_n);
    chk("off_n", 0, so_n);
    ev[0] <= 1'b1;
    wt(8);
    ev[0] <= 1'b0;
    rdc("state", PMG_STATE_OFS, 1);
    $display("suspend test done");
    apb(1, PMG_CTRL_OFS, 0);
    apb(1, PMG_STATUS_OFS, 32'hffff);
    apb(1, PMG_MASK_OFS, 32'hffff);
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 15'h7ff0 : 15'($random(seed)) & 15'h7ff0;
      ev <= v;
      wt(8);
      rdc("level", PMG_LEVEL_OFS, lvl(v));
      rdc("status", PMG_STATUS_OFS, lvl(v));
      chk("irq", |v, irq);
      chk("alert", v[8], mi);
      ev <= '0;
      wt(8);
      apb(1, PMG_STATUS_OFS, 32'hffff);
    end
    $display("event test done");
    for (int i = 2; i < 4; i++)
    begin
      ev[i] <= 1'b1;
      wt(8);
      chk("cbrst", 0, cr_n);
      ev[i] <= 1'b0;
      wt(120);
      chk("cbrst", 1, cr_n);
    end
    ev[1] <= 1'b1;
    wt(8);
    chk("cbrst", 0, cr_n);
    wt(200);
    chk("cbrst", 1, cr_n);
    ev[1] <= 1'b0;
    apb(1, PMG_CTRL_OFS, 1);
    wt(3);
    chk("cbrst", 0, cr_n);
    wt(110);
    apb(1, PMG_CTRL_OFS, 32'h0020_0030);
    for (n = 0; n < 70000 && wd !== 1'b1; n++)
      wt(1);
    chk("wdt", 1, wd);
    wt(3);
    chk("cbrst", 0, cr_n);
    apb(1, PMG_CTRL_OFS, 32'h40);
    wt(3);
    chk("trip_n", 0, tt_n);
    apb(0, 8'h20, 32'h0);
    chk("slverr", 1, err);
    $display("reset test done");
    stop_test();
  end
endmodule : test_pmg_power_mgmt
